// [hdl/cms01_defs.svh]
`ifndef CMS01_DEFS_SVH
`define CMS01_DEFS_SVH

// Timing
`define CMS_CLK_NS      40
`define CMS_SLOT_NS     1280000
`define CMS_SLOT_FIRST  4'h1
`define CMS_SLOT_LAST   4'hF
`define CMS_SLOT_NONE   4'h0

// Start-up mode code on the two select pins; boot counter capture and done counts
`define CMS_MODE_SEL    2'h1
`define CMS_BOOT_DONE   2'h3
`define CMS_BOOT_CAPT   2'h2

// Register byte offsets
`define CMS_ADDR_CTRL   8'h00
`define CMS_ADDR_STAT   8'h04
`define CMS_ADDR_SYS    8'h08
`define CMS_ADDR_CSLOT  8'h0C
`define CMS_ADDR_RSLOT  8'h10
`define CMS_ADDR_CVSEL  8'h14
`define CMS_ADDR_RVSEL  8'h18

// Control bits
`define CMS_CTRL_RELOAD 0
`define CMS_CTRL_START  1
`define CMS_CTRL_OFF    2

// System defaults
`define CMS_POWER_BUTTON_POLARITY_DEF  1'h1
`define CMS_USB_HI_DEF  1'h1
`define CMS_WDOG_DEF    2'h0
`define CMS_SER_DEF     1'h0
`define CMS_OSC_DEF     1'h1
`define CMS_TICK_DEF    1'h1
`define CMS_RTCSRC_DEF  1'h0
`define CMS_R1PIN_DEF   1'h0
`define CMS_XTAL_DEF    1'h0
`define CMS_DBT_DEF     2'h0
`define CMS_WAKE_MS     6'h28

// Supply defaults
`define CMS_C1_SLOT     4'h1
`define CMS_C3_SLOT     4'h2
`define CMS_C4_SLOT     4'h3
`define CMS_C6_SLOT     4'h4
`define CMS_C1_VSEL     7'h62
`define CMS_C3_VSEL     7'h0E
`define CMS_C4_VSEL     7'h0E
`define CMS_C6_VSEL     7'h26
`define CMS_CX_VSEL     7'h00
`define CMS_R1_VSEL     5'h02
`define CMS_R2_VSEL     5'h1A
`define CMS_R3_VSEL     5'h1F
`define CMS_R4_VSEL     5'h1F

// Pin defaults
`define CMS_FN_GPIO     4'h0
`define CMS_FN_WAKE     4'h2
`define CMS_FN_ALT      4'h3

`endif

// [hdl/cms01_pkg.sv]
package cms01_pkg;

   typedef enum logic [1:0]
   {
      CMS01_IDLE   = 2'b00,
      CMS01_LOAD   = 2'b01,
      CMS01_STEP   = 2'b11,
      CMS01_ACTIVE = 2'b10
   } cms01_state_e;

   typedef struct packed
   {
      logic       power_button_polarity;
      logic       usb_slave_high_limit_select;
      logic [1:0] watchdog_mode_field;
      logic       serial_three_line_select;
      logic       serial_four_line_select;
      logic       serial_config_select;
      logic       slow_oscillator_enable;
      logic       realtime_tick_enable;
      logic       realtime_clock_source;
      logic       regulator1_pin_control_mode;
      logic       regulator1_pin_enable;
      logic       crystal_detect_enable;
   } cms01_sys_s;

   typedef struct packed
   {
      logic [3:0] pin_function_select;
      logic       pin_direction;
      logic       pin_polarity_config;
      logic       pin_pullup_enable;
      logic       pin_pulldown_enable;
      logic       pin_debounce_enable;
   } cms01_pin_s;

   typedef struct packed
   {
      logic [3:0] converter_enable_timeslot;
      logic [6:0] converter_voltage_code;
   } cms01_conv_s;

   typedef struct packed
   {
      logic [3:0] regulator_enable_timeslot;
      logic [4:0] regulator_voltage_code;
   } cms01_reg_s;

   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } cms01_apb_req_s;

endpackage

// [hdl/cms01_seq.sv]
`timescale 1ns/1ps
`include "cms01_defs.svh"

// Summary of operation
// - Defaults load at reset in any mode; the sequence runs only when select pins read 01.
// - A supply with timeslot 0000 never starts automatically.
// - Load power button polarity 1, ON input active low.
// - Load USB slave high limit select 1, the 500mA limit.
// - Load watchdog mode field 00, watchdog disabled.
// - Clear the serial select bits so the interface is 2-wire.
// - Load slow oscillator enable 1 so 32kHz oscillator runs.
// - Enable the realtime tick, clock source select 0.
// - Clear regulator1 pin control mode and pin enable.
// - No crystal detect: reset output never waits for crystal.
// - Timeslots spaced about 1.28ms, supplies enabled at their slot.
// - Limit switch never closed automatically.
// - Converter 1: slot 0001, voltage code 110_0010.
// - Converter 3: slot 0010, voltage code 000_1110.
// - Converter 4: slot 0011, voltage code 000_1110.
// - Converter 6: slot 0100, voltage code 010_0110.
// - Converters 2 and 5: slot 0000, left disabled.
// - Regulators slot 0000; codes 0_0010, 1_1010, 1_1111, 1_1111.
// - GPIO2 function 0011, 32kHz open-drain output, no pull.
// - GPIO10 function 0011, charger indicator open-drain output.
// - GPIO11 function 0010 wakeup input, config 1 means active low.
// - GPIO12 function 0011 line switch, CMOS output, config 0.
// - Other GPIOs function 0000, inputs, config 1, no pulls.
// - Debounce on all GPIOs; wake debounce is setting plus 40ms.

module cms01_seq
#(
   parameter int SLOT_CYC = `CMS_SLOT_NS / `CMS_CLK_NS
)
(
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire cms01_pkg::cms01_apb_req_s apb_req,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   config_select_pin_high,
   input  wire logic                   config_select_pin_low,
   input  wire logic                   power_button_pin,
   output cms01_pkg::cms01_sys_s       sys_cfg,
   output cms01_pkg::cms01_pin_s [12:0] pin_cfg,
   output logic [1:0]                  debounce_time_setting,
   output logic [5:0]                  wake_debounce_ms,
   output cms01_pkg::cms01_conv_s [5:0] conv_cfg,
   output logic [5:0]                  conv_enable,
   output cms01_pkg::cms01_reg_s [3:0] reg_cfg,
   output logic [3:0]                  reg_enable,
   output logic                        limit_switch_close,
   output logic                        reset_out_n
);
   import cms01_pkg::*;

   localparam int TMR_W = $clog2(SLOT_CYC + 1);

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic slot_hit
   (
      input logic [3:0] ts,
      input logic [3:0] slot
   );
      slot_hit = (ts != `CMS_SLOT_NONE) && (ts == slot);
   endfunction

   function automatic logic reg_mapped
   (
      input logic [7:0] addr
   );
      case (addr)
         `CMS_ADDR_CTRL, `CMS_ADDR_STAT, `CMS_ADDR_SYS,
         `CMS_ADDR_CSLOT, `CMS_ADDR_RSLOT,
         `CMS_ADDR_CVSEL, `CMS_ADDR_RVSEL:
            reg_mapped = 1'b1;
         default:
            reg_mapped = 1'b0;
      endcase
   endfunction

   function automatic cms01_pin_s pin_default
   (
      input int idx
   );
      pin_default.pin_function_select = `CMS_FN_GPIO;
      pin_default.pin_direction       = 1'b1;
      pin_default.pin_polarity_config = 1'b1;
      pin_default.pin_pullup_enable   = 1'b0;
      pin_default.pin_pulldown_enable = 1'b0;
      pin_default.pin_debounce_enable = 1'b1;
      case (idx)
         2, 10:
         begin
            pin_default.pin_function_select = `CMS_FN_ALT;
            pin_default.pin_direction       = 1'b0;
         end
         11:
            pin_default.pin_function_select = `CMS_FN_WAKE;
         12:
         begin
            pin_default.pin_function_select = `CMS_FN_ALT;
            pin_default.pin_direction       = 1'b0;
            pin_default.pin_polarity_config = 1'b0;
         end
         default:
            pin_default.pin_direction = 1'b1;
      endcase
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [1:0]   conf_meta;
   logic [1:0]   conf_sync;
   logic         on_meta;
   logic         on_sync;
   logic         on_prev;
   logic         on_active;
   logic         on_evt;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         conf_meta <= 2'h0;
         conf_sync <= 2'h0;
         on_meta   <= 1'b1;
         on_sync   <= 1'b1;
      end
      else
      begin
         conf_meta <= {config_select_pin_high, config_select_pin_low};
         conf_sync <= conf_meta;
         on_meta   <= power_button_pin;
         on_sync   <= on_meta;
      end
   end

   // Polarity 1 turns a low level on the pin into an active request
   assign on_active = on_sync ^ sys_cfg.power_button_polarity;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         on_prev <= 1'b1;
      else
         on_prev <= on_active;
   end

   // Starts high so reset itself never reads as a press
   assign on_evt = on_active & ~on_prev;

   // ****************************************
   // Mode capture after the synchronisers fill
   // ****************************************
   logic [1:0]   boot_cnt;
   logic         mode_ok;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         boot_cnt <= 2'h0;
      else if (boot_cnt != `CMS_BOOT_DONE)
         boot_cnt <= boot_cnt + 2'h1;
   end

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         mode_ok <= 1'b0;
      else if (boot_cnt == `CMS_BOOT_CAPT)
         mode_ok <= (conf_sync == `CMS_MODE_SEL);
   end

   // ****************************************
   // Bus slave
   // ****************************************
   logic         wr_en;
   logic         rd_setup;
   logic         ctrl_reload;
   logic         start_wr;
   logic         off_wr;
   cms01_state_e state;
   logic [3:0]   slot;
   logic [TMR_W-1:0] timer;
   logic [31:0]  next_rdata;

   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite
                  & reg_mapped(apb_req.paddr);
   assign rd_setup = apb_req.psel & ~apb_req.penable;
   assign pready  = 1'b1;
   assign pslverr = apb_req.psel & apb_req.penable
                    & ~reg_mapped(apb_req.paddr);

   assign start_wr = wr_en && (apb_req.paddr == `CMS_ADDR_CTRL)
                     && apb_req.pwdata[`CMS_CTRL_START];
   assign off_wr   = wr_en && (apb_req.paddr == `CMS_ADDR_CTRL)
                     && apb_req.pwdata[`CMS_CTRL_OFF];

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         ctrl_reload <= 1'b1;
      else if (wr_en && (apb_req.paddr == `CMS_ADDR_CTRL))
         ctrl_reload <= apb_req.pwdata[`CMS_CTRL_RELOAD];
   end

   always_comb
   begin
      next_rdata = 32'h0;
      case (apb_req.paddr)
         `CMS_ADDR_CTRL:
            next_rdata[`CMS_CTRL_RELOAD] = ctrl_reload;
         `CMS_ADDR_STAT:
            next_rdata = {4'h0, reg_enable, 2'h0, conv_enable,
                          7'h0, mode_ok, slot, 2'h0, state};
         `CMS_ADDR_SYS:
            next_rdata = {17'h0, debounce_time_setting, sys_cfg};
         `CMS_ADDR_CSLOT:
            next_rdata = {8'h0,
                          conv_cfg[5].converter_enable_timeslot,
                          conv_cfg[4].converter_enable_timeslot,
                          conv_cfg[3].converter_enable_timeslot,
                          conv_cfg[2].converter_enable_timeslot,
                          conv_cfg[1].converter_enable_timeslot,
                          conv_cfg[0].converter_enable_timeslot};
         `CMS_ADDR_RSLOT:
            next_rdata = {16'h0,
                          reg_cfg[3].regulator_enable_timeslot,
                          reg_cfg[2].regulator_enable_timeslot,
                          reg_cfg[1].regulator_enable_timeslot,
                          reg_cfg[0].regulator_enable_timeslot};
         `CMS_ADDR_CVSEL:
            next_rdata = {4'h0,
                          conv_cfg[5].converter_voltage_code,
                          conv_cfg[3].converter_voltage_code,
                          conv_cfg[2].converter_voltage_code,
                          conv_cfg[0].converter_voltage_code};
         `CMS_ADDR_RVSEL:
            next_rdata = {12'h0,
                          reg_cfg[3].regulator_voltage_code,
                          reg_cfg[2].regulator_voltage_code,
                          reg_cfg[1].regulator_voltage_code,
                          reg_cfg[0].regulator_voltage_code};
         default:
            next_rdata = 32'h0;
      endcase
   end

   // Captured in the setup cycle so the data is a flop in the access
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
         prdata <= 32'h0;
      else if (rd_setup)
         prdata <= next_rdata;
   end

   // ****************************************
   // Default loading
   // ****************************************
   logic load_now;

   // Clearing the reload bit keeps whatever software left behind
   assign load_now = sys_rst || (state == CMS01_LOAD && ctrl_reload);

   always_ff @(posedge core_clk)
   begin
      if (load_now)
      begin
         sys_cfg.power_button_polarity       <= `CMS_POWER_BUTTON_POLARITY_DEF;
         sys_cfg.usb_slave_high_limit_select <= `CMS_USB_HI_DEF;
         sys_cfg.watchdog_mode_field         <= `CMS_WDOG_DEF;
         sys_cfg.serial_three_line_select    <= `CMS_SER_DEF;
         sys_cfg.serial_four_line_select     <= `CMS_SER_DEF;
         sys_cfg.serial_config_select        <= `CMS_SER_DEF;
         sys_cfg.slow_oscillator_enable      <= `CMS_OSC_DEF;
         sys_cfg.realtime_tick_enable        <= `CMS_TICK_DEF;
         sys_cfg.realtime_clock_source       <= `CMS_RTCSRC_DEF;
         sys_cfg.regulator1_pin_control_mode <= `CMS_R1PIN_DEF;
         sys_cfg.regulator1_pin_enable       <= `CMS_R1PIN_DEF;
         sys_cfg.crystal_detect_enable       <= `CMS_XTAL_DEF;
         debounce_time_setting               <= `CMS_DBT_DEF;
      end
      else if (wr_en && (apb_req.paddr == `CMS_ADDR_SYS))
      begin
         sys_cfg               <= apb_req.pwdata[12:0];
         debounce_time_setting <= apb_req.pwdata[14:13];
      end
   end

   assign wake_debounce_ms = `CMS_WAKE_MS
                             + {4'h0, debounce_time_setting};

   always_ff @(posedge core_clk)
   begin
      if (load_now)
      begin
         conv_cfg[0] <= {`CMS_C1_SLOT, `CMS_C1_VSEL};
         conv_cfg[1] <= {`CMS_SLOT_NONE, `CMS_CX_VSEL};
         conv_cfg[2] <= {`CMS_C3_SLOT, `CMS_C3_VSEL};
         conv_cfg[3] <= {`CMS_C4_SLOT, `CMS_C4_VSEL};
         conv_cfg[4] <= {`CMS_SLOT_NONE, `CMS_CX_VSEL};
         conv_cfg[5] <= {`CMS_C6_SLOT, `CMS_C6_VSEL};
      end
      else if (wr_en && (apb_req.paddr == `CMS_ADDR_CSLOT))
      begin
         for (int i = 0; i < 6; i++)
            conv_cfg[i].converter_enable_timeslot <= apb_req.pwdata[4*i +: 4];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (load_now)
      begin
         reg_cfg[0] <= {`CMS_SLOT_NONE, `CMS_R1_VSEL};
         reg_cfg[1] <= {`CMS_SLOT_NONE, `CMS_R2_VSEL};
         reg_cfg[2] <= {`CMS_SLOT_NONE, `CMS_R3_VSEL};
         reg_cfg[3] <= {`CMS_SLOT_NONE, `CMS_R4_VSEL};
      end
      else if (wr_en && (apb_req.paddr == `CMS_ADDR_RSLOT))
      begin
         for (int i = 0; i < 4; i++)
            reg_cfg[i].regulator_enable_timeslot <= apb_req.pwdata[4*i +: 4];
      end
   end

   genvar g;
   generate
      for (g = 0; g < 13; g++)
      begin : g_pin
         always_ff @(posedge core_clk)
         begin
            if (load_now)
               pin_cfg[g] <= pin_default(g);
         end
      end
   endgenerate

   // ****************************************
   // Power-up sequencer
   // ****************************************
   logic slot_end;

   assign slot_end = (timer == TMR_W'(SLOT_CYC - 1));

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state <= CMS01_IDLE;
         slot  <= `CMS_SLOT_NONE;
         timer <= '0;
      end
      else if (off_wr)
      begin
         state <= CMS01_IDLE;
         slot  <= `CMS_SLOT_NONE;
         timer <= '0;
      end
      else
      begin
         case (state)
            CMS01_IDLE:
               if (mode_ok && (on_evt || start_wr))
                  state <= CMS01_LOAD;
            CMS01_LOAD:
            begin
               state <= CMS01_STEP;
               slot  <= `CMS_SLOT_FIRST;
               timer <= '0;
            end
            CMS01_STEP:
               if (slot_end)
               begin
                  timer <= '0;
                  if (slot == `CMS_SLOT_LAST)
                     state <= CMS01_ACTIVE;
                  else
                     slot <= slot + 4'h1;
               end
               else
                  timer <= timer + TMR_W'(1);
            CMS01_ACTIVE:
               state <= CMS01_ACTIVE;
            default:
               state <= CMS01_IDLE;
         endcase
      end
   end

   // Enables only accumulate while stepping; off drops them all
   always_ff @(posedge core_clk)
   begin
      if (sys_rst || off_wr || state == CMS01_IDLE)
      begin
         conv_enable <= 6'h00;
         reg_enable  <= 4'h0;
      end
      else if (state == CMS01_STEP)
      begin
         for (int i = 0; i < 6; i++)
            if (slot_hit(conv_cfg[i].converter_enable_timeslot, slot))
               conv_enable[i] <= 1'b1;
         for (int i = 0; i < 4; i++)
            if (slot_hit(reg_cfg[i].regulator_enable_timeslot, slot))
               reg_enable[i] <= 1'b1;
      end
   end

   assign limit_switch_close = 1'b0;

   // Crystal wait is off in this mode, so release follows the sequence
   assign reset_out_n = (state == CMS01_ACTIVE);

   // ****************************************
   // Checks
   // ****************************************
   mode_gate_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_IDLE && !mode_ok) |=> state == CMS01_IDLE)
      else $error("sequence left idle without mode 01");

   zero_slot_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_STEP && conv_cfg[1].converter_enable_timeslot == 4'h0
       && !conv_enable[1]) |=> !conv_enable[1])
      else $error("supply with slot zero was enabled");

   pol_load_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_LOAD && ctrl_reload)
      |=> sys_cfg.power_button_polarity && sys_cfg.usb_slave_high_limit_select)
      else $error("polarity or USB limit not loaded");

   iface_load_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_LOAD && ctrl_reload)
      |=> !sys_cfg.serial_three_line_select && !sys_cfg.serial_four_line_select
          && sys_cfg.watchdog_mode_field == 2'h0)
      else $error("interface or watchdog defaults wrong");

   slot_step_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_STEP && $past(state) == CMS01_STEP && $changed(slot))
      |-> $past(timer) == TMR_W'(SLOT_CYC - 1) && slot == $past(slot) + 4'h1)
      else $error("slot advanced at the wrong time");

   conv1_cfg_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_LOAD && ctrl_reload)
      |=> conv_cfg[0] == {4'h1, 7'h62} && conv_cfg[5] == {4'h4, 7'h26})
      else $error("converter defaults wrong");

   load_order_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_LOAD && !off_wr)
      |=> state == CMS01_STEP && slot == 4'h1 ##1 conv_enable[0])
      else $error("sequence did not start at slot one");

   wake_pin_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      (state == CMS01_LOAD && ctrl_reload)
      |=> pin_cfg[11].pin_function_select == 4'h2
          && pin_cfg[11].pin_polarity_config
          && pin_cfg[12].pin_direction == 1'b0)
      else $error("wake pin defaults wrong");

   release_a: assert property (
      @(posedge core_clk) disable iff (sys_rst)
      $rose(reset_out_n) |-> $past(state) == CMS01_STEP
                             && $past(slot) == 4'hF && !limit_switch_close)
      else $error("reset released out of order");

endmodule

// [verif/cms01_board.sv]
`timescale 1ns/1ps
// ****************************************
// Board side: mode strap pins and ON button
// ****************************************
module cms01_board
(
   input  wire logic core_clk,
   output logic      config_select_pin_high,
   output logic      config_select_pin_low,
   output logic      power_button_pin
);
   initial
   begin
      config_select_pin_high = 1'b0;
      config_select_pin_low  = 1'b1;
      power_button_pin       = 1'b1;
   end
   task set_mode(input logic [1:0] m);
      @(posedge core_clk);
      {config_select_pin_high, config_select_pin_low} <= m;
   endtask
   // Held long enough to clear the two-stage synchroniser
   task press();
      @(posedge core_clk);
      power_button_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
      power_button_pin <= 1'b1;
   endtask
endmodule

// [verif/custom_mode01_startup_defaults_bench.sv]
`timescale 1ns/1ps
module custom_mode01_startup_defaults_bench;
   import cms01_pkg::*;
   localparam int SC = 8;
   localparam logic [8:0] PIN_EXP [13] = '{9'h019, 9'h019, 9'h069,
      9'h019, 9'h019, 9'h019, 9'h019, 9'h019, 9'h019, 9'h019,
      9'h069, 9'h059, 9'h061};
   localparam logic [10:0] CONV_EXP [6] = '{{4'h1, 7'h62},
      {4'h0, 7'h00}, {4'h2, 7'h0E}, {4'h3, 7'h0E}, {4'h0, 7'h00},
      {4'h4, 7'h26}};
   localparam logic [8:0] REG_EXP [4] = '{{4'h0, 5'h02},
      {4'h0, 5'h1A}, {4'h0, 5'h1F}, {4'h0, 5'h1F}};
   logic                 core_clk;
   logic                 sys_rst;
   cms01_apb_req_s       req;
   logic [31:0]          prdata;
   logic [31:0]          q;
   logic                 pready;
   logic                 pslverr;
   logic                 err;
   logic                 cph;
   logic                 cpl;
   logic                 pbp;
   cms01_sys_s           sys_cfg;
   cms01_pin_s [12:0]    pin_cfg;
   logic [1:0]           dbt;
   logic [5:0]           wms;
   cms01_conv_s [5:0]    conv_cfg;
   logic [5:0]           conv_en;
   cms01_reg_s [3:0]     reg_cfg;
   logic [3:0]           reg_en;
   logic                 lsw;
   logic                 rst_n;
   int                   fails;
   int                   n_tests;
   int                   n;

   cms01_seq #(.SLOT_CYC(SC)) dut
   (
      .core_clk(core_clk), .sys_rst(sys_rst), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .config_select_pin_high(cph), .config_select_pin_low(cpl),
      .power_button_pin(pbp), .sys_cfg(sys_cfg), .pin_cfg(pin_cfg),
      .debounce_time_setting(dbt), .wake_debounce_ms(wms),
      .conv_cfg(conv_cfg), .conv_enable(conv_en), .reg_cfg(reg_cfg),
      .reg_enable(reg_en), .limit_switch_close(lsw), .reset_out_n(rst_n)
   );
   cms01_board board
   (
      .core_clk(core_clk), .config_select_pin_high(cph),
      .config_select_pin_low(cpl), .power_button_pin(pbp)
   );

   // ****************************************
   // Helpers
   // ****************************************
   initial
   begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("Error at %0t: %s got %h", $time, m, got);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk);
      req.penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      q = prdata;
      err = pslverr;
      req <= '0;
   endtask
   task do_reset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (16) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask
   task stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (3000) @(posedge core_clk);
      fails++;
      stop_test();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      fails = 0;
      n_tests = 0;
      req = '0;
      sys_rst = 1'b1;
      do_reset();
      @(negedge core_clk);
      chk(sys_cfg[12:9], 4'hC, "pol usb wdog");
      chk(sys_cfg[8:3], 6'h06, "iface osc rtc");
      chk(sys_cfg[2:0], 3'h0, "ldo1 xtal");
      for (int i = 0; i < 13; i++)
         chk(pin_cfg[i], PIN_EXP[i], "pin");
      for (int i = 0; i < 6; i++)
         chk(conv_cfg[i], CONV_EXP[i], "conv");
      for (int i = 0; i < 4; i++)
         chk(reg_cfg[i], REG_EXP[i], "ldo");
      chk({dbt, wms}, {2'h0, 6'd40}, "wake");
      apb(1'b0, 8'hFC, 32'h0);
      chk({err, q}, {1'b1, 32'h0}, "unmapped");
      apb(1'b0, 8'h00, 32'h0);
      chk(q[0], 1'b1, "reload");
      // Polarity kept at 1 so the write cannot fake a button press
      apb(1'b1, 8'h08, 32'h77CF);
      apb(1'b0, 8'h08, 32'h0);
      chk({wms, q[15:0]}, {6'd43, 16'h77CF}, "sys write");
      $display("defaults done");
      board.press();
      do @(negedge core_clk); while (conv_en[0] !== 1'b1);
      chk({reg_en, conv_en}, 10'h001, "slot1");
      chk({wms, sys_cfg}, {6'd40, 13'h1830}, "reloaded");
      repeat (SC) @(negedge core_clk);
      chk({reg_en, conv_en}, 10'h005, "slot2");
      repeat (SC) @(negedge core_clk);
      chk({reg_en, conv_en}, 10'h00D, "slot3");
      repeat (SC) @(negedge core_clk);
      chk({reg_en, conv_en}, 10'h02D, "slot4");
      n = 3 * SC;
      while (rst_n !== 1'b1)
      begin
         @(negedge core_clk);
         n++;
      end
      chk(n >= 15 * SC - 2 && n <= 15 * SC, 1'b1, "active");
      chk(lsw, 1'b0, "switch");
      apb(1'b0, 8'h04, 32'h0);
      chk({q[27:24], q[21:16], q[1:0]}, 12'h0B6, "status");
      apb(1'b1, 8'h00, 32'h5);
      @(negedge core_clk);
      chk({rst_n, reg_en, conv_en}, 11'h0, "off");
      $display("sequence done");
      board.set_mode(2'b10);
      do_reset();
      apb(1'b1, 8'h00, 32'h3);
      board.press();
      repeat (4 * SC) @(negedge core_clk);
      chk({rst_n, reg_en, conv_en}, 11'h0, "mode10");
      apb(1'b0, 8'h04, 32'h0);
      chk({q[8], q[1:0]}, 3'h0, "mode10 status");
      $display("mode select done");
      stop_test();
   end
endmodule
